// ==== src/mcac_core_access.sv ====
// Address translation and access control for a 4096-word, 24-bit core store.
// Assumes a 50 MHz clock, a synchronous active-low reset and an AXI4-Lite master.
`include "mcac_params.svh"

module mcac_core_access (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sense amplifier outputs from the core planes
    input wire logic [23:0] core_store_sense,
    // Drive line selection
    output logic [31:0] x_diverter,
    output logic [31:0] y_diverter,
    output logic [1:0] read_gen_low_half,
    output logic [1:0] read_gen_high_half,
    output logic [1:0] write_gen_low_half,
    output logic [1:0] write_gen_high_half,
    // Bit plane control
    output logic [23:0] bit_plane_control_inhibit,
    output logic [23:0] core_store_write_data
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding functions

    // Octal stage: three bits to one of eight, gated by recirculation
    function automatic logic [7:0] oct_xlate(input logic [2:0] b, input logic gate);
        logic [7:0] o;
        o = 8'h00;
        for (int i = 0; i < 8; i++) begin
            o[i] = gate && (b == 3'(i));
        end
        return o;
    endfunction

    // Quaternary stage: each output is one three-input AND of true/false bits and the gate
    function automatic logic [3:0] quat_xlate(input logic [1:0] b, input logic gate);
        logic [3:0] q;
        q[0] = ~b[1] & ~b[0] & gate;
        q[1] = ~b[1] & b[0] & gate;
        q[2] = b[1] & ~b[0] & gate;
        q[3] = b[1] & b[0] & gate;
        return q;
    endfunction

    // Diverter decoder: two-input AND of every octal and quaternary pair
    function automatic logic [31:0] div_decode(input logic [5:0] half, input logic gate);
        logic [7:0] o;
        logic [3:0] q;
        logic [31:0] d;
        o = oct_xlate(half[2:0], gate);
        q = quat_xlate(half[4:3], gate);
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 8; i++) begin
                d[j * 8 + i] = q[j] & o[i];
            end
        end
        return d;
    endfunction

    // Initiate-probe groups for a write, from the field modifier
    function automatic logic [3:0] fm_probes(input logic [2:0] fm);
        logic [3:0] g;
        g = 4'h0;
        if (fm == 3'h1 || fm == 3'h5) begin
            g = 4'b1110;
        end else if (fm == 3'h2 || fm == 3'h6) begin
            g = 4'b1001;
        end else if (fm == `MCAC_FM_UPPER) begin
            g = 4'b0111;
        end else if (fm == 3'h4) begin
            g = 4'b1100;
        end
        return g;
    endfunction

    // Word mask of the active probe groups
    function automatic logic [23:0] probe_mask(input logic [3:0] g);
        return ({24{g[0]}} & `MCAC_PG_0_7) | ({24{g[1]}} & `MCAC_PG_8_14) |
               ({24{g[2]}} & `MCAC_PG_15) | ({24{g[3]}} & `MCAC_PG_16_23);
    endfunction

    // Byte-enable merge of a bus write into a register
    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] v;
        v = old;
        for (int k = 0; k < 4; k++) begin
            if (s[k]) begin
                v[k * 8 +: 8] = d[k * 8 +: 8];
            end
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    mcac_pkg::mcac_state_t r;
    mcac_pkg::mcac_state_t next_r;
    logic tick;
    logic wr_fire;
    logic [31:0] ctrl_old;
    logic [31:0] ctrl_new;
    logic [31:0] rd_word;
    logic rd_hit;

    // Step interval divider output
    assign tick = (r.phase == mcac_pkg::MCAC_RUN) && (r.div_cnt == 6'(`MCAC_STEP_CYC - 1));
    assign wr_fire = r.aw_got && r.w_got && !r.bvalid;
    assign ctrl_old = {25'h0, r.fm, 2'b00, r.write_ref, 1'b0};
    assign ctrl_new = apply_strb(ctrl_old, r.w_data, r.w_strb);

    // Read mux; unmapped offsets answer with a slave error
    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `MCAC_REG_CTRL: rd_word = ctrl_old;
            `MCAC_REG_ADDR: rd_word = {20'h0, r.addr};
            `MCAC_REG_NEWDATA: rd_word = {8'h0, r.new_data};
            `MCAC_REG_STATUS: rd_word = {16'h0, r.probe, r.init_probe, r.step, r.done,
                                         r.phase == mcac_pkg::MCAC_RUN, r.recirc};
            `MCAC_REG_BUFFER: rd_word = {8'h0, r.buffer};
            default: rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_r = r;
        // Sense synchroniser, second stage is the only reader of the first
        next_r.sense_s1 = core_store_sense;
        next_r.sense_s2 = r.sense_s1;

        // Bus write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_r.aw_got = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_r.w_got = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = rd_word;
            next_r.rresp = rd_hit ? `MCAC_RESP_OKAY : `MCAC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end

        // Timing chain: step advances once per interval through the last step
        if (r.phase == mcac_pkg::MCAC_RUN) begin
            next_r.div_cnt = tick ? 6'h00 : r.div_cnt + 6'h01;
            if (tick) begin
                next_r.step = r.step + 5'h01;
                unique case (r.step)
                    `MCAC_ST_TRANS - 5'h01: begin
                        next_r.recirc = 1'b1;
                    end
                    `MCAC_ST_READ - 5'h01: begin
                        next_r.read_on = 1'b1;
                    end
                    `MCAC_ST_PROBE_EN - 5'h01: begin
                        // Same chain for every reference; only the probe groups differ
                        next_r.probe_en = 1'b1;
                        next_r.init_probe = r.write_ref ? fm_probes(r.fm) : 4'hf;
                    end
                    `MCAC_ST_PROBE - 5'h01: begin
                        next_r.probe = r.init_probe & {4{r.probe_en}};
                    end
                    `MCAC_ST_SENSE - 5'h01: begin
                        // Kept bits only; sensed ones elsewhere are dropped
                        next_r.buffer = r.buffer | (r.sense_s2 & probe_mask(r.probe));
                    end
                    `MCAC_ST_MERGE - 5'h01: begin
                        if (r.write_ref) begin
                            next_r.buffer = r.buffer | (r.new_data & ~probe_mask(r.probe));
                        end
                    end
                    `MCAC_ST_STOP_READ - 5'h01: begin
                        next_r.read_on = 1'b0;
                        next_r.inh_grp = 3'h7;
                    end
                    `MCAC_ST_INHIBIT - 5'h01: begin
                        // Three stages of eight planes each; a one suppresses inhibit
                        for (int g = 0; g < 3; g++) begin
                            next_r.inhibit[g * 8 +: 8] = {8{r.inh_grp[g]}} & ~r.buffer[g * 8 +: 8];
                        end
                        next_r.inh_grp = 3'h0;
                    end
                    `MCAC_ST_WRITE - 5'h01: begin
                        next_r.write_on = 1'b1;
                    end
                    `MCAC_ST_RECIRC_END - 5'h01: begin
                        next_r.recirc = 1'b0;
                    end
                    `MCAC_ST_STOP_WRITE - 5'h01: begin
                        next_r.write_on = 1'b0;
                    end
                    `MCAC_ST_LAST: begin
                        next_r.inhibit = 24'h0;
                        next_r.probe = 4'h0;
                        next_r.probe_en = 1'b0;
                        next_r.init_probe = 4'h0;
                        next_r.done = 1'b1;
                        next_r.step = 5'h00;
                        next_r.phase = mcac_pkg::MCAC_IDLE;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Register writes; address, data and control are frozen while a reference runs
        if (wr_fire) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = `MCAC_RESP_OKAY;
            if (r.aw_addr == `MCAC_REG_CTRL) begin
                if (r.phase == mcac_pkg::MCAC_IDLE) begin
                    next_r.write_ref = ctrl_new[`MCAC_CTRL_WRITE];
                    next_r.fm = ctrl_new[`MCAC_CTRL_FM_LO +: 3];
                    if (ctrl_new[`MCAC_CTRL_CLRBUF]) begin
                        next_r.buffer = 24'h0;
                    end
                    if (ctrl_new[`MCAC_CTRL_START]) begin
                        next_r.phase = mcac_pkg::MCAC_RUN;
                        next_r.step = 5'h00;
                        next_r.div_cnt = 6'h00;
                        next_r.done = 1'b0;
                        if (ctrl_new[`MCAC_CTRL_WRITE]) begin
                            next_r.buffer = 24'h0;
                        end
                    end
                end
            end else if (r.aw_addr == `MCAC_REG_ADDR) begin
                if (r.phase == mcac_pkg::MCAC_IDLE) begin
                    next_r.addr = 12'(apply_strb({20'h0, r.addr}, r.w_data, r.w_strb));
                end
            end else if (r.aw_addr == `MCAC_REG_NEWDATA) begin
                if (r.phase == mcac_pkg::MCAC_IDLE) begin
                    next_r.new_data = 24'(apply_strb({8'h0, r.new_data}, r.w_data, r.w_strb));
                end
            end else if (r.aw_addr != `MCAC_REG_STATUS && r.aw_addr != `MCAC_REG_BUFFER) begin
                next_r.bresp = `MCAC_RESP_SLVERR;
            end
        end

        // Registered translators; low half drives X, high half drives Y
        next_r.x_div = div_decode(r.addr[5:0], r.recirc);
        next_r.y_div = div_decode(r.addr[11:6], r.recirc);
        // Pair choice from the top bit of each half, X in bit 0 and Y in bit 1
        next_r.rg_lo = {~r.addr[11], ~r.addr[5]} & {2{r.recirc & r.read_on}};
        next_r.rg_hi = {r.addr[11], r.addr[5]} & {2{r.recirc & r.read_on}};
        next_r.wg_lo = {~r.addr[11], ~r.addr[5]} & {2{r.recirc & r.write_on}};
        next_r.wg_hi = {r.addr[11], r.addr[5]} & {2{r.recirc & r.write_on}};
    end

    // Single register stage for all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Ready signals stall while a response waits, keeping one write and one read in flight
    assign s_axi_awready = !r.aw_got && !r.bvalid;
    assign s_axi_wready = !r.w_got && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign x_diverter = r.x_div;
    assign y_diverter = r.y_div;
    assign read_gen_low_half = r.rg_lo;
    assign read_gen_high_half = r.rg_hi;
    assign write_gen_low_half = r.wg_lo;
    assign write_gen_high_half = r.wg_hi;
    assign bit_plane_control_inhibit = r.inhibit;
    // Buffer drives the planes during the whole write step, kept bits included
    assign core_store_write_data = r.buffer & {24{r.write_on}};

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking chk_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    x_div_select_a: assert property ($past(r.recirc) |-> (r.x_div == (32'h1 << $past(r.addr[4:0]))))
        else $error("X diverter does not match address");
    y_div_onehot_a: assert property ((|r.y_div) |-> $onehot(r.y_div))
        else $error("Y diverter not one-hot");
    gen_pair_a: assert property ((r.wg_hi[0] || r.rg_hi[0]) |-> $past(r.addr[5]))
        else $error("High generator pair with top bit zero");
    recirc_gate_a: assert property ((!r.recirc && !$past(r.recirc)) |=> (r.x_div == 32'h0 && r.rg_lo == 2'h0))
        else $error("Decode active without recirculation");
    probe_latch_a: assert property ((tick && r.step == `MCAC_ST_PROBE - 5'h01) |=> r.probe == $past(r.init_probe))
        else $error("Read probes not set from initiate latches");
    full_write_a: assert property ((tick && r.step == 5'h03 && r.write_ref && r.fm == 3'h0) |=> r.init_probe == 4'h0)
        else $error("Modifier zero activated probes");
    read_probes_a: assert property ((tick && r.step == 5'h03 && !r.write_ref) |=> r.init_probe == 4'hf)
        else $error("Read reference missing probe groups");
    inhibit_zero_a: assert property ((|r.inhibit) |-> ((r.inhibit & r.buffer) == 24'h0))
        else $error("Inhibit on a plane writing one");
    step_restart_a: assert property ((wr_fire && r.aw_addr == `MCAC_REG_CTRL && r.phase == mcac_pkg::MCAC_IDLE
                                      && r.w_strb[0] && r.w_data[0]) |=> (r.step == 5'h00 && tick == 1'b0))
        else $error("Step counter did not restart");
    recirc_window_a: assert property ((tick && r.step == `MCAC_ST_RECIRC_END - 5'h01) |=> !r.recirc)
        else $error("Recirculation not ended on time");

    // Pair and window gating of the generators
    gen_excl_a: assert property (((r.rg_lo & r.rg_hi) | (r.wg_lo & r.wg_hi)) == 2'h0)
        else $error("Both pairs on");
    read_window_a: assert property (!$past(r.read_on) |-> (r.rg_lo | r.rg_hi) == 2'h0)
        else $error("Read pair out of window");

    // Probe enable, then only probed bits captured
    probe_enable_a: assert property ((tick && r.step == 5'h03) |=> r.probe_en)
        else $error("No probe enable");
    sense_keep_a: assert property ((tick && r.step == 5'h06) |=>
        (r.buffer & ~$past(r.buffer) & ~probe_mask($past(r.probe))) == 24'h0)
        else $error("Unprobed bit kept");

    // Inhibit quiet between references
    inhibit_idle_a: assert property (r.phase == mcac_pkg::MCAC_IDLE |-> r.inhibit == 24'h0)
        else $error("Inhibit while idle");

    // Step stays within the chain
    step_bound_a: assert property (r.step <= `MCAC_ST_LAST)
        else $error("Step past the last");

endmodule

// ==== src/mcac_params.svh ====
// Constants of the core store address and access controller: offsets, fields, steps, timing.
// Assumes a 50 MHz clock and a 32-bit AXI4-Lite register bus.
//
// Overview of operation
// - Low six address bits pick the X drive line, high six the Y line.
// - Three lowest bits of each half become eight one-hot octal signals.
// - Next two bits become four quaternary signals from three-input AND terms.
// - Octal and quaternary pairs give 32 one-hot diverter enables.
// - One generator pair finishes the 64-line choice; diverters share all generators.
// - Top half bit 0 enables first read/write pair, 1 enables the second.
// - Every translator and pair choice is gated by translation recirculation control.
// - Same timing per reference; reading or writing set only by probe groups.
// - At step 5 initiate-probe latches AND probe enable set read-probe latches.
// - During clear, sensed ones load the buffer only where probes are active.
// - Field modifier 0 activates no probe groups: the whole word is replaced.
// - Modifier 1 or 5 keeps bits 8-23, replacing only bits 0-7.
// - Modifier 2 or 6 keeps bits 0-7 and 16-23, replacing bits 8-15.
// - Upper-third write keeps bits 0-15, replacing bits 16-23.
// - Modifier 4 keeps bit 15 and bits 16-23, replacing bits 0-14.
// - Write step writes every buffer bit, kept and newly merged, into cores.
// - Read reference activates all four probe groups and restores afterwards.
// - Read reference ignores the modifier; read-operand pulse sets initiate latches.
// - Start-inhibit pulse fans out to 24 planes through three eight-wide stages.
// - Each plane gets inhibit current when writing zero, none when writing one.
`ifndef MCAC_PARAMS_SVH
`define MCAC_PARAMS_SVH
// Register byte offsets
`define MCAC_REG_CTRL 12'h000
`define MCAC_REG_ADDR 12'h004
`define MCAC_REG_NEWDATA 12'h008
`define MCAC_REG_STATUS 12'h00c
`define MCAC_REG_BUFFER 12'h010
// Control fields
`define MCAC_CTRL_START 0
`define MCAC_CTRL_WRITE 1
`define MCAC_CTRL_CLRBUF 2
`define MCAC_CTRL_FM_LO 4
// Field modifier chosen for the upper-third write
`define MCAC_FM_UPPER 3'h3
// Probe groups as word masks
`define MCAC_PG_0_7 24'h0000ff
`define MCAC_PG_8_14 24'h007f00
`define MCAC_PG_15 24'h008000
`define MCAC_PG_16_23 24'hff0000
// Timing chain steps
`define MCAC_ST_TRANS 5'h01
`define MCAC_ST_READ 5'h03
`define MCAC_ST_PROBE_EN 5'h04
`define MCAC_ST_PROBE 5'h05
`define MCAC_ST_SENSE 5'h07
`define MCAC_ST_MERGE 5'h08
`define MCAC_ST_STOP_READ 5'h09
`define MCAC_ST_INHIBIT 5'h0a
`define MCAC_ST_WRITE 5'h0b
`define MCAC_ST_RESUME 5'h0d
`define MCAC_ST_RECIRC_END 5'h0f
`define MCAC_ST_STOP_WRITE 5'h11
`define MCAC_ST_LAST 5'h14
// Step interval
`define MCAC_CLK_NS 20
`define MCAC_STEP_NS 1000
`define MCAC_STEP_CYC ((`MCAC_STEP_NS + `MCAC_CLK_NS - 1) / `MCAC_CLK_NS)
// Bus responses
`define MCAC_RESP_OKAY 2'h0
`define MCAC_RESP_SLVERR 2'h2
`endif

// ==== src/mcac_pkg.sv ====
// Types of the core store address and access controller.
// Assumes mcac_params.svh for all numeric constants.
package mcac_pkg;
    typedef enum logic [1:0] {
        MCAC_IDLE = 2'b00,
        MCAC_RUN = 2'b01
    } mcac_phase_t;

    typedef struct packed {
        mcac_phase_t phase;
        logic [4:0] step;
        logic [5:0] div_cnt;
        logic write_ref;
        logic [2:0] fm;
        logic [11:0] addr;
        logic [23:0] new_data;
        logic [23:0] buffer;
        logic [3:0] init_probe;
        logic probe_en;
        logic [3:0] probe;
        logic recirc;
        logic read_on;
        logic write_on;
        logic [31:0] x_div;
        logic [31:0] y_div;
        logic [1:0] rg_lo;
        logic [1:0] rg_hi;
        logic [1:0] wg_lo;
        logic [1:0] wg_hi;
        logic [2:0] inh_grp;
        logic [23:0] inhibit;
        logic done;
        logic [23:0] sense_s1;
        logic [23:0] sense_s2;
        logic aw_got;
        logic [11:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mcac_state_t;
endpackage

// ==== verif/mcac_core_model.sv ====
// Behavioural core store standing behind the drive lines, inhibit lines and sense wires.
// Assumes one-hot diverters and generator pairs as driven by mcac_core_access.
module mcac_core_model (
    // Clock
    input wire logic aclk,
    // Drive line selection
    input wire logic [31:0] x_diverter,
    input wire logic [31:0] y_diverter,
    input wire logic [1:0] read_gen_low_half,
    input wire logic [1:0] read_gen_high_half,
    input wire logic [1:0] write_gen_low_half,
    input wire logic [1:0] write_gen_high_half,
    // Plane inhibit and sense
    input wire logic [23:0] bit_plane_control_inhibit,
    output logic [23:0] core_store_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem [4096];
    logic [23:0] last_seen;
    logic [11:0] addr;
    logic rd_on;
    logic wr_on;
    function automatic logic [4:0] line_of(input logic [31:0] v);
        line_of = 5'h00;
        for (int i = 0; i < 32; i++) if (v[i]) line_of = i[4:0];
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Address rebuilt from the diverter and the generator half that is on
    assign rd_on = |{read_gen_low_half, read_gen_high_half};
    assign wr_on = |{write_gen_low_half, write_gen_high_half};
    assign addr = {read_gen_high_half[1] | write_gen_high_half[1], line_of(y_diverter),
                   read_gen_high_half[0] | write_gen_high_half[0], line_of(x_diverter)};
    initial begin
        foreach (mem[i]) mem[i] = 24'h000000;
        last_seen = 24'h000000;
    end
    // Cores take a one wherever the plane inhibit is withheld
    always @(posedge aclk) begin
        if (wr_on) mem[addr] <= ~bit_plane_control_inhibit;
        if (rd_on) last_seen <= mem[addr];
    end
    // Released sense wires show the inverse of the last word, so stale data cannot pass
    assign core_store_sense = rd_on ? mem[addr] : ~last_seen;
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the core store access controller.
// Assumes mcac_params.svh and the core store model beside the design.
`include "mcac_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [1:0] rsp;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp, rgl, rgh, wgl, wgh;
    wire [31:0] rdata, xd, yd;
    wire [23:0] sense, inh, wr_data;
    int error_cnt, checked, cyc;
    mcac_core_access i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_store_sense(sense),
        .x_diverter(xd), .y_diverter(yd), .read_gen_low_half(rgl), .read_gen_high_half(rgh),
        .write_gen_low_half(wgl), .write_gen_high_half(wgh), .bit_plane_control_inhibit(inh),
        .core_store_write_data(wr_data));
    mcac_core_model i_model (.aclk(aclk), .x_diverter(xd), .y_diverter(yd), .read_gen_low_half(rgl),
        .read_gen_high_half(rgh), .write_gen_low_half(wgl), .write_gen_high_half(wgh),
        .bit_plane_control_inhibit(inh), .core_store_sense(sense));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling above the run's needs
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test;
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Bus cycles; ready is sampled mid-cycle since inputs only move at rising edges
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            da |= ta;
            dw |= tw;
        end while (!(da && dw));
        do @(negedge aclk); while (!bvalid);
        rsp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        rd = rdata;
        rsp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    function automatic logic [23:0] keep(input logic [2:0] fm);
        case (fm)
            3'h1, 3'h5: keep = `MCAC_PG_8_14 | `MCAC_PG_15 | `MCAC_PG_16_23;
            3'h2, 3'h6: keep = `MCAC_PG_0_7 | `MCAC_PG_16_23;
            `MCAC_FM_UPPER: keep = `MCAC_PG_0_7 | `MCAC_PG_8_14 | `MCAC_PG_15;
            3'h4: keep = `MCAC_PG_15 | `MCAC_PG_16_23;
            default: keep = 24'h000000;
        endcase
    endfunction
    // One reference, watching drive lines, plane data and the buffer on the way
    task automatic run(input logic wr_ref, input logic [2:0] fm, input logic [11:0] a, input logic [23:0] nd,
                       input logic [23:0] exp);
        wr(`MCAC_REG_ADDR, {20'h00000, a});
        wr(`MCAC_REG_NEWDATA, {8'h00, nd});
        wr(`MCAC_REG_CTRL, 32'h1 | (32'(wr_ref) << `MCAC_CTRL_WRITE) | (32'(!wr_ref) << `MCAC_CTRL_CLRBUF)
           | (32'(fm) << `MCAC_CTRL_FM_LO));
        do @(negedge aclk); while (!(|{rgl, rgh}));
        chk("x_diverter", xd, 32'h1 << a[4:0]);
        chk("y_diverter", yd, 32'h1 << a[10:6]);
        chk("read_gens", {28'h0, rgh, rgl}, {28'h0, a[11], a[5], ~a[11], ~a[5]});
        do @(negedge aclk); while (!(|{wgl, wgh}));
        chk("write_gens", {28'h0, wgh, wgl}, {28'h0, a[11], a[5], ~a[11], ~a[5]});
        chk("plane_data", {8'h00, wr_data}, {8'h00, exp});
        chk("inhibit", {8'h00, inh}, {8'h00, 24'(~exp)});
        do rd_reg(`MCAC_REG_STATUS); while (rd[2] !== 1'b1);
        chk("busy", {31'h0, rd[1]}, 32'h0);
        chk("x_idle", xd, 32'h0);
        rd_reg(`MCAC_REG_BUFFER);
        chk("buffer", rd, {8'h00, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_bus;
        rd_reg(`MCAC_REG_STATUS);
        chk("status_reset", rd, 32'h0);
        wr(12'h020, 32'h1);
        chk("bresp_unmapped", {30'h0, rsp}, 32'h2);
        rd_reg(12'h020);
        chk("rresp_unmapped", {30'h0, rsp}, 32'h2);
        chk("rdata_unmapped", rd, 32'h0);
    endtask
    // Full write then a read that carries a modifier it must ignore
    task automatic t_full;
        run(1'b1, 3'h0, 12'h9c9, 24'ha5c33c, 24'ha5c33c);
        run(1'b0, 3'h2, 12'h9c9, 24'h000000, 24'ha5c33c);
        rd_reg(`MCAC_REG_CTRL);
        chk("ctrl", rd, 32'h20);
    endtask
    // Every partial-write modifier over a known word, then read back
    task automatic t_fields;
        logic [11:0] a;
        logic [23:0] m;
        for (int f = 1; f < 7; f++) begin
            a = {4{f[2:0]}};
            m = (24'h5a3cc3 & keep(f[2:0])) | (24'hc3a55a & ~keep(f[2:0]));
            run(1'b1, 3'h0, a, 24'h5a3cc3, 24'h5a3cc3);
            run(1'b1, f[2:0], a, 24'hc3a55a, m);
            run(1'b0, 3'h7, a, 24'h000000, m);
        end
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        error_cnt = 0;
        checked = 0;
        cyc = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_bus();
        t_full();
        t_fields();
        finish_test();
    end
endmodule
